// >>> hw/fwm_write_manager.sv
// Flash write manager: protects regions, skips unchanged bytes, merges groups.
// Assumes the array read port answers combinationally for the request address.
// Assumes inputs synchronous to clk_in and a reset held for one edge or more.
// Slow timing comes from a cycle counter, not from a second clock.
module fwm_write_manager #(
    parameter int BUSY_CYCLES = fwm_pkg::ERASE_WRITE_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Request side
    input wire logic req_valid_in,
    input fwm_pkg::fwm_req_type req_in,
    output logic req_ready_out,
    // Control
    input wire logic flush_in,
    // Array side
    input wire logic [7:0] array_rdata_in,
    output logic [15:0] array_raddr_out,
    output logic prog_valid_out,
    output fwm_pkg::fwm_prog_type prog_out,
    output logic prog_onchip_out,
    // Answer and status
    output fwm_pkg::fwm_resp_type resp_out,
    output logic busy_out
);
    // Manager states, Gray coded along idle -> commit -> wait
    // Idle gathers bytes and answers at once; commit hands the group
    // to the array once the busy window is over; wait holds the port
    // until the erase/write cycle has run out.
    typedef enum logic [1:0] {
        FWM_IDLE = 2'b00,
        FWM_COMMIT = 2'b01,
        FWM_WAIT = 2'b11
    } fwm_state_type;

    // Manager state and the group being gathered
    fwm_state_type state;            // Current state
    fwm_state_type next_state;
    fwm_pkg::fwm_prog_type grp;      // Pending merge group
    fwm_pkg::fwm_prog_type next_grp;
    fwm_pkg::fwm_req_type held;      // Request waiting behind a commit
    fwm_pkg::fwm_req_type next_held;
    logic held_v;                    // Held request present
    logic next_held_v;
    // Registered outputs
    fwm_pkg::fwm_resp_type resp;     // Registered answer
    fwm_pkg::fwm_resp_type next_resp;
    fwm_pkg::fwm_prog_type prog;     // Registered program command
    fwm_pkg::fwm_prog_type next_prog;
    logic prog_v;
    logic next_prog_v;
    // Decode results, recomputed every cycle
    logic timer_busy;                // Array busy window running
    logic in_fw;                     // Request lands in firmware region
    logic same;                      // Request data equals stored byte
    logic fits;                      // Request extends the pending group
    logic [15:0] req_base;           // Group base of the request
    logic [2:0] req_idx;             // Byte slot of the request
    logic [63:0] grp_data_upd;       // Group data with new byte placed

    // Busy timer for one physical cycle
    // It starts on the program pulse, so the window is counted from the
    // cycle in which the array really sees the command.
    fwm_busy_timer #(.CYCLES(BUSY_CYCLES)) u_timer (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .start_in(prog_v),
        .busy_out(timer_busy)
    );

    // Request decode
    // Everything here looks at the request as it stands this cycle;
    // the stored byte arrives through the combinational read port.
    // A request fits only when its base matches and its slot is free,
    // so a repeated slot never overwrites data still waiting to commit.
    always_comb begin
        req_base = {req_in.addr[15:3], 3'h0};
        req_idx = req_in.addr[2:0];
        // Address below the firmware bound
        in_fw = (req_in.addr < fwm_pkg::FW_REGION_END);
        same = (array_rdata_in == req_in.data);
        // Free slot in the same eight-byte group
        fits = (grp.mask != 8'h00) && (grp.base == req_base) && !grp.mask[req_idx];
        // Place the new byte in its slot of a copy of the group
        grp_data_upd = grp.data;
        for (int i = 0; i < fwm_pkg::GROUP_N; i++) begin
            if (i == int'(req_idx)) begin
                grp_data_upd[i*8 +: 8] = req_in.data;
            end
        end
    end

    // Next-state logic for group, answers and program commands
    // Priority in idle, highest first:
    //   a new request, unless one is already held;
    //   the held request, once the array is free again;
    //   a flush or a full group.
    // Refusal is checked before the compare, so a network write into
    // the firmware region never reads as already stored.
    // Merged bytes are answered when they are taken, not when they
    // reach the array; a reset before the commit loses them.
    // A request that does not fit is held and answered only after the
    // partial group has gone out and its busy window has ended.
    // Only one physical cycle is ever in flight; the timer gates both
    // the commit and the return to idle.
    always_comb begin
        next_state = state;
        next_grp = grp;
        next_held = held;
        next_held_v = held_v;
        next_resp = '0;
        next_prog = prog;
        next_prog_v = 1'b0;
        case (state)
            FWM_IDLE: begin
                if (req_valid_in && !held_v) begin
                    // The network may not touch the firmware that carries it
                    if (req_in.src == fwm_pkg::FWM_SRC_NET && in_fw) begin
                        next_resp = '{done: 1'b1, rejected: 1'b1, skipped: 1'b0};
                    end else if (same) begin
                        next_resp = '{done: 1'b1, rejected: 1'b0, skipped: 1'b1};
                    end else if (fits || grp.mask == 8'h00) begin
                        // Program or network into application space both land here
                        next_grp.base = req_base;
                        next_grp.data = grp_data_upd;
                        next_grp.mask[req_idx] = 1'b1;
                        next_resp = '{done: 1'b1, rejected: 1'b0, skipped: 1'b0};
                        // A request without merge closes the group at once
                        if (!req_in.merge) begin
                            next_state = FWM_COMMIT;
                        end
                    end else begin
                        // Park the request; the partial group goes out first
                        next_held = req_in;
                        next_held_v = 1'b1;
                        next_state = FWM_COMMIT;
                    end
                end else if (held_v && !timer_busy) begin
                    // Restart the held request as a fresh group
                    next_grp.base = {held.addr[15:3], 3'h0};
                    next_grp.mask = 8'h00;
                    next_grp.mask[held.addr[2:0]] = 1'b1;
                    for (int i = 0; i < fwm_pkg::GROUP_N; i++) begin
                        if (i == int'(held.addr[2:0])) begin
                            next_grp.data[i*8 +: 8] = held.data;
                        end
                    end
                    next_held_v = 1'b0;
                    next_resp = '{done: 1'b1, rejected: 1'b0, skipped: 1'b0};
                    next_state = held.merge ? FWM_IDLE : FWM_COMMIT;
                end else if ((flush_in || grp.mask == 8'hff) && grp.mask != 8'h00) begin
                    next_state = FWM_COMMIT;
                end
            end
            FWM_COMMIT: begin
                // Hand the group over once the array is free
                if (!timer_busy) begin
                    next_prog = grp;
                    next_prog_v = 1'b1;
                    // The array now owns these bytes
                    next_grp = '0;
                    next_state = FWM_WAIT;
                end
            end
            FWM_WAIT: begin
                // Stay until the timer and the pulse are both gone
                if (!timer_busy && !prog_v) begin
                    next_state = FWM_IDLE;
                end
            end
            default: begin
                // Unused code falls back to idle
                next_state = FWM_IDLE;
            end
        endcase
    end

    // Register all manager state
    // Reset clears the group, so merged bytes not yet committed are lost.
    // Every register here loads only constants on reset.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= FWM_IDLE;
            grp <= '0;
            held <= '0;
            held_v <= 1'b0;
            resp <= '0;
            prog <= '0;
            prog_v <= 1'b0;
        end else begin
            state <= next_state;
            grp <= next_grp;
            held <= next_held;
            held_v <= next_held_v;
            resp <= next_resp;
            prog <= next_prog;
            prog_v <= next_prog_v;
        end
    end

    // Outputs
    // Ready is combinational so a request is taken in the first idle cycle with no request held.
    // The read address follows the request, which the array answers at once.
    assign req_ready_out = (state == FWM_IDLE) && !held_v;
    assign array_raddr_out = req_in.addr;
    assign prog_valid_out = prog_v;
    assign prog_out = prog;
    // Application space spans on-chip window and off-chip memory
    assign prog_onchip_out = (prog.base >= fwm_pkg::ONCHIP_BASE) &&
        (prog.base < fwm_pkg::ONCHIP_BASE + fwm_pkg::ONCHIP_SIZE);
    assign resp_out = resp;
    // Busy also covers the hand-over, not only the timer window
    assign busy_out = timer_busy || (state != FWM_IDLE);
endmodule

// >>> hw/fwm_pkg.sv
// Package for the flash write manager: address map, timing and carriers.
// Assumes a 100 MHz single clock and a byte-wide nonvolatile array port.
package fwm_pkg;
    // Clock rate and physical cycle time
    localparam int CLK_HZ = 100000000;
    localparam int ERASE_WRITE_MS = 20;
    localparam int ERASE_WRITE_CYCLES = (CLK_HZ / 1000) * ERASE_WRITE_MS;
    // Address widths and region bounds
    localparam int ADDR_W = 16;
    localparam logic [15:0] FW_REGION_END = 16'h4000;   // First 16 KB hold firmware
    localparam logic [15:0] ONCHIP_BASE = 16'h4000;     // On-chip flash window base
    localparam logic [15:0] ONCHIP_SIZE = 16'h1000;     // On-chip flash window size
    localparam int GROUP_N = 8;                         // Bytes merged per cycle
    localparam int GROUP_IDX_W = 3;
    // Source of a write request
    typedef enum logic [1:0] {
        FWM_SRC_LOCAL = 2'h0,   // Local processor
        FWM_SRC_PROG = 2'h1,    // External device programmer
        FWM_SRC_NET = 2'h2      // Network management download
    } fwm_src_type;
    // Write request carrier
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        fwm_src_type src;
        logic merge;            // Allow grouping with neighbours
    } fwm_req_type;
    // Answer carrier
    typedef struct packed {
        logic done;             // Request finished
        logic rejected;         // Refused by region protection
        logic skipped;          // Data already stored, no cycle used
    } fwm_resp_type;
    // Array program command carrier
    typedef struct packed {
        logic [15:0] base;      // Address of first byte of the group
        logic [7:0] mask;       // Which group bytes carry new data
        logic [63:0] data;      // Group data, byte i at bits 8i+7:8i
    } fwm_prog_type;
endpackage

// >>> hw/fwm_busy_timer.sv
// Down counter that holds the array busy for one erase/write cycle.
// Assumes a single clock; the start pulse is ignored while counting.
module fwm_busy_timer #(
    parameter int CYCLES = fwm_pkg::ERASE_WRITE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic start_in,
    output logic busy_out
);
    logic [31:0] count;      // Cycles left in the busy window
    logic [31:0] next_count;

    // Load on start, count down to zero
    always_comb begin
        next_count = count;
        if (start_in && count == 32'h0) begin
            next_count = CYCLES[31:0];
        end else if (count != 32'h0) begin
            next_count = count - 32'h1;
        end
    end

    // Register the count
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count <= 32'h0;
        end else begin
            count <= next_count;
        end
    end

    assign busy_out = (count != 32'h0);
endmodule

// >>> tb/fwm_flash_model.sv
// Flash array model: erased cells read ff, group programs land masked.
// Assumes a group base whose low three bits select no byte.
module fwm_flash_model (
    input wire logic clk_in,
    input wire logic [15:0] raddr_in,
    input wire logic prog_valid_in,
    input fwm_pkg::fwm_prog_type prog_in,
    output logic [7:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];  // Array cells
    // Start erased, with a firmware image already in the lowest 16 KB
    initial begin
        foreach (mem[i]) mem[i] = (i < 16'h4000) ? (8'(i) ^ 8'h5a) : 8'hff;
    end
    // Stored byte for the compare before a write
    assign rdata_out = mem[raddr_in];
    // One program pulse updates every masked byte of the group
    always @(posedge clk_in) begin
        if (prog_valid_in === 1'b1) begin
            for (int i = 0; i < 8; i++) begin
                if (prog_in.mask[i]) mem[{prog_in.base[15:3], 3'(i)}] <= prog_in.data[8*i +: 8];
            end
        end
    end
endmodule

// >>> tb/fwm_wm_assertions.sv
// Checker for the flash write manager ports.
// Bound to every fwm_write_manager instance.
module fwm_wm_checker #(parameter int BUSY_CYCLES = 20) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic req_valid_in,
    input fwm_pkg::fwm_req_type req_in,
    input wire logic req_ready_out,
    input wire logic [7:0] array_rdata_in,
    input wire logic prog_valid_out,
    input fwm_pkg::fwm_prog_type prog_out,
    input wire logic prog_onchip_out,
    input fwm_pkg::fwm_resp_type resp_out,
    input wire logic busy_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    logic tk;
    logic fw;
    // Request taken, and a network write aimed at firmware
    assign tk = req_valid_in && req_ready_out;
    assign fw = req_in.src == fwm_pkg::FWM_SRC_NET && req_in.addr < fwm_pkg::FW_REGION_END;
    a_busy_hold: assert property (prog_valid_out |=> busy_out [*8])
        else $error("busy dropped after program");
    a_ready_idle: assert property (req_ready_out |-> !busy_out)
        else $error("ready while busy");
    a_one_cycle: assert property (prog_valid_out |=> !prog_valid_out [*8])
        else $error("program inside busy window");
    a_fw_reject: assert property (tk && fw |=> resp_out.done && resp_out.rejected)
        else $error("firmware write not refused");
    a_skip_same: assert property (tk && !fw && !req_in.merge && req_in.data == array_rdata_in
        |=> resp_out.skipped ##1 !prog_valid_out)
        else $error("unchanged byte not skipped");
    a_app_accept: assert property (tk && req_in.addr >= fwm_pkg::ONCHIP_BASE
        |=> !resp_out.rejected)
        else $error("application write refused");
    a_onchip_map: assert property (prog_valid_out |-> prog_onchip_out == (prog_out.base >=
        fwm_pkg::ONCHIP_BASE && prog_out.base < 16'h5000))
        else $error("on-chip decode wrong");
    a_mask_set: assert property (prog_valid_out |-> prog_out.mask != 8'h00)
        else $error("empty group programmed");
endmodule

bind fwm_write_manager fwm_wm_checker #(.BUSY_CYCLES(BUSY_CYCLES)) chk_u (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .req_valid_in(req_valid_in),
    .req_in(req_in),
    .req_ready_out(req_ready_out),
    .array_rdata_in(array_rdata_in),
    .prog_valid_out(prog_valid_out),
    .prog_out(prog_out),
    .prog_onchip_out(prog_onchip_out),
    .resp_out(resp_out),
    .busy_out(busy_out)
);

// >>> tb/fwm_write_manager_tb.sv
// Testbench for the flash write manager with a flash array model.
// Assumes a shortened busy count; inputs move on falling edges.
module fwm_write_manager_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BC = 20;
    logic clk_in, rst_b_in, req_valid_in, req_ready_out, flush_in, prog_valid_out;
    logic prog_onchip_out, busy_out, pon;
    logic [7:0] array_rdata_in;
    logic [15:0] array_raddr_out;
    fwm_pkg::fwm_req_type req_in;
    fwm_pkg::fwm_prog_type prog_out, pl;
    fwm_pkg::fwm_resp_type resp_out, rl;
    int num_errors = 0;
    int check_count = 0;
    int pc = 0;
    int p;
    fwm_write_manager #(.BUSY_CYCLES(BC)) dut_u (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .req_valid_in(req_valid_in),
        .req_in(req_in),
        .req_ready_out(req_ready_out),
        .flush_in(flush_in),
        .array_rdata_in(array_rdata_in),
        .array_raddr_out(array_raddr_out),
        .prog_valid_out(prog_valid_out),
        .prog_out(prog_out),
        .prog_onchip_out(prog_onchip_out),
        .resp_out(resp_out),
        .busy_out(busy_out)
    );
    fwm_flash_model mem_u (.clk_in(clk_in), .raddr_in(array_raddr_out),
        .prog_valid_in(prog_valid_out), .prog_in(prog_out), .rdata_out(array_rdata_in));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Record each group program pulse
    always @(posedge clk_in) begin
        if (prog_valid_out === 1'b1) begin
            pc++;
            pl = prog_out;
            pon = prog_onchip_out;
        end
    end
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Wait for idle, bounded; returns the cycles waited
    task automatic idle(output int n);
        n = 0;
        while (req_ready_out !== 1'b1 && n < 200) begin
            @(negedge clk_in);
            n++;
        end
        chk(n < 200, 1'b1);
    endtask
    // Offer one byte write and wait for its answer
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input fwm_pkg::fwm_src_type s,
        input logic m);
        int n;
        req_in = '{a, d, s, m};
        req_valid_in = 1'b1;
        idle(n);
        @(negedge clk_in);
        req_valid_in = 1'b0;
        n = 0;
        while (resp_out.done !== 1'b1 && n < 200) begin
            @(negedge clk_in);
            n++;
        end
        rl = resp_out;
        chk(rl.done, 1'b1);
        repeat (3) @(negedge clk_in);
    endtask
    // Single write, busy span, then same byte again
    task automatic t_single();
        int n;
        p = pc;
        wr(16'h4010, 8'h5a, fwm_pkg::FWM_SRC_PROG, 1'b0);
        chk({rl.rejected, rl.skipped, pc - p}, {1'b0, 1'b0, 32'd1});
        chk(busy_out, 1'b1);
        chk({pl.base, pl.mask, pl.data[7:0], pon}, {16'h4010, 8'h01, 8'h5a, 1'b1});
        idle(n);
        chk(n >= BC - 5, 1);
        wr(16'h4010, 8'h5a, fwm_pkg::FWM_SRC_LOCAL, 1'b0);
        chk({rl.skipped, pc - p}, {1'b1, 32'd1});
    endtask
    // Network write into firmware region and a full merged group
    task automatic t_net();
        int n;
        p = pc;
        wr(16'h0100, 8'h12, fwm_pkg::FWM_SRC_NET, 1'b0);
        chk({rl.rejected, pc - p}, {1'b1, 32'd0});
        chk(array_rdata_in, 8'h5a);
        for (int i = 0; i < 8; i++) begin
            wr(16'h4100 + 16'(i), 8'h10 + 8'(i), fwm_pkg::FWM_SRC_NET, 1'b1);
        end
        idle(n);
        chk(pc - p, 1);
        chk({pl.base, pl.mask}, {16'h4100, 8'hff});
        chk(pl.data, 64'h1716151413121110);
    endtask
    // Partial group broken by another group, then flushed
    task automatic t_part();
        int n;
        p = pc;
        wr(16'h5000, 8'ha1, fwm_pkg::FWM_SRC_LOCAL, 1'b1);
        wr(16'h5001, 8'ha2, fwm_pkg::FWM_SRC_LOCAL, 1'b1);
        wr(16'h5010, 8'hb0, fwm_pkg::FWM_SRC_LOCAL, 1'b1);
        chk({pc - p == 1, pl.base, pl.mask}, {1'b1, 16'h5000, 8'h03});
        chk({pl.data[15:0], pon}, {16'ha2a1, 1'b0});
        idle(n);
        flush_in = 1'b1;
        @(negedge clk_in);
        flush_in = 1'b0;
        repeat (4) @(negedge clk_in);
        chk({pc - p, pl.base, pl.mask, pl.data[7:0]}, {32'd2, 16'h5010, 8'h01, 8'hb0});
    endtask
    task automatic conclude();
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        rst_b_in = 1'b0;
        req_valid_in = 1'b0;
        flush_in = 1'b0;
        req_in = '0;
        repeat (16) @(negedge clk_in);
        rst_b_in = 1'b1;
        @(negedge clk_in);
        t_single();
        t_net();
        t_part();
        conclude();
    end
    // Watchdog well beyond the expected run
    initial begin
        #50000;
        num_errors++;
        conclude();
    end
endmodule
